// >>> shared/tms_regs.vh
`ifndef TMS_REGS_VH
`define TMS_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define TMS_OPC_WRITE_HI 5'h10
`define TMS_OPC_READ_HI 5'h16
`define TMS_OPC_INIT 8'h70
`define TMS_OPC_POR 8'h50
`define TMS_OPC_START_CYCLE 8'h01
`define TMS_OPC_START_TEMP 8'h02
`define TMS_OPC_CAL_RES 8'h03
`define TMS_OPC_CAL_TDC 8'h04
// ----------------------------------------
// Register indices and fields
// ----------------------------------------
`define TMS_REG_MEASURE_CLOCK 3'h0
`define TMS_REG_HIT_SELECT 3'h1
`define TMS_REG_WINDOW_FIRST 3'h2
`define TMS_REG_WINDOW_SECOND 3'h3
`define TMS_REG_CONFIG4 3'h4
`define TMS_REG_CONFIG5 3'h5
`define TMS_RD_STATUS 3'h4
`define TMS_BIT_FAST_INIT 15
`define TMS_BIT_JITTER 20
`define TMS_BIT_FAST_OSC 11
`define TMS_BIT_RANGE2 3
`define TMS_FIRST_SEL_LSB 16
`define TMS_SECOND_SEL_LSB 20
`define TMS_CFG_RESET 24'h00_0000
// ----------------------------------------
// Example timing figures
// ----------------------------------------
`define TMS_CAL_PERIODS 8
`define TMS_REF_PERIOD_NS 30518
`define TMS_FIRE_PULSES 3
`define TMS_FIRE_PERIOD_NS 1000
`define TMS_WIN1_US 50
`define TMS_WIN2_US 51
`define TMS_WIN3_US 52
`define TMS_TIMEOUT_US 1024
`define TMS_SETTLE_US 640
`define TMS_ALU_NS 4600
`define TMS_HITS 3
`define TMS_CLK_NS 50
`define TMS_STAT_TIMEOUT 16'h0200
`endif

// >>> logic/tms_spi_port.v
`timescale 1ns/1ps
`include "tms_regs.vh"
// ----------------------------------------
// Serial port, mode 1, sampled on system clock
// ----------------------------------------
module tms_spi_port (
    // System
    input wire clk_in,
    input wire rst_n_in,
    // Serial pins
    input wire ssn_in,
    input wire sck_in,
    input wire si_in,
    output reg so_out,
    // Decoded stream
    output reg opc_valid_out,
    output reg [7:0] opc_out,
    output reg wr_valid_out,
    output reg [31:0] frame_out,
    // Read word to shift
    input wire [31:0] rd_word_in
);
    reg sck_d_reg;
    reg [5:0] cnt_reg;
    reg [31:0] sh_reg;
    reg [31:0] rd_reg;
    wire rise = sck_in & ~sck_d_reg;
    wire fall = ~sck_in & sck_d_reg;

    // Shift in on falling edge, out on rising edge
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_d_reg <= 1'b0;
            cnt_reg <= 6'h00;
            sh_reg <= 32'h0000_0000;
            rd_reg <= 32'h0000_0000;
            so_out <= 1'b0;
            opc_valid_out <= 1'b0;
            opc_out <= 8'h00;
            wr_valid_out <= 1'b0;
            frame_out <= 32'h0000_0000;
        end else begin
            sck_d_reg <= sck_in;
            opc_valid_out <= 1'b0;
            wr_valid_out <= 1'b0;
            if (ssn_in) begin
                cnt_reg <= 6'h00;
            end else begin
                if (fall) begin
                    sh_reg <= {sh_reg[30:0], si_in};
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'h07) begin
                        opc_valid_out <= 1'b1;
                        opc_out <= {sh_reg[6:0], si_in};
                    end
                    if (cnt_reg == 6'h1f) begin
                        wr_valid_out <= 1'b1;
                        frame_out <= {sh_reg[30:0], si_in};
                    end
                end
                // Read word follows the opcode register, one cycle after decode
                if (opc_valid_out) rd_reg <= rd_word_in;
                if (rise && cnt_reg >= 6'h08) begin
                    so_out <= rd_reg[31];
                    rd_reg <= {rd_reg[30:0], 1'b0};
                end
            end
        end
    end
endmodule // tms_spi_port

// >>> logic/tms_measure_sequencer.v
`timescale 1ns/1ps
`include "tms_regs.vh"
module tms_measure_sequencer #(
    parameter SETTLE_CYC = (`TMS_SETTLE_US * 1000) / `TMS_CLK_NS,
    parameter TIMEOUT_CYC = (`TMS_TIMEOUT_US * 1000) / `TMS_CLK_NS,
    parameter CAL_CYC = (`TMS_CAL_PERIODS * `TMS_REF_PERIOD_NS) / `TMS_CLK_NS
) (
    // System
    input wire clk_sys_in,
    input wire rst_n_in,
    // Serial port
    input wire ssn_in,
    input wire sck_in,
    input wire si_in,
    output wire so_out,
    // Measurement pins
    input wire start_in,
    input wire stop_channel_one_in,
    output reg fire_out,
    output reg fast_osc_on_out,
    output reg done_line_n_out
);
    // ----------------------------------------
    // Reset release and serial port
    // ----------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) rst_sync_reg <= 2'b00;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    wire opc_valid;
    wire [7:0] opc;
    wire wr_valid;
    wire [31:0] frame;
    reg [31:0] rd_word;
    tms_spi_port u_port (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .ssn_in(ssn_in),
        .sck_in(sck_in),
        .si_in(si_in),
        .so_out(so_out),
        .opc_valid_out(opc_valid),
        .opc_out(opc),
        .wr_valid_out(wr_valid),
        .frame_out(frame),
        .rd_word_in(rd_word)
    );

    // ----------------------------------------
    // Timing constants
    // ----------------------------------------
    localparam W1_CYC = (`TMS_WIN1_US * 1000) / `TMS_CLK_NS;
    localparam W2_CYC = (`TMS_WIN2_US * 1000) / `TMS_CLK_NS;
    localparam W3_CYC = (`TMS_WIN3_US * 1000) / `TMS_CLK_NS;
    localparam ALU_CYC = (`TMS_ALU_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS;
    localparam FIRE_HALF = `TMS_FIRE_PERIOD_NS / (2 * `TMS_CLK_NS);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    reg [23:0] measure_clock_config_reg;
    reg [23:0] hit_select_config_reg;
    reg [23:0] stop_window_first_config_reg;
    reg [23:0] stop_window_second_config_reg;
    reg [23:0] cfg4_reg;
    reg [23:0] cfg5_reg;
    wire is_write = opc_valid == 1'b0 && wr_valid && frame[31:27] == `TMS_OPC_WRITE_HI;
    wire [2:0] wr_adr = frame[26:24];
    wire por = opc_valid && opc == `TMS_OPC_POR;
    wire fast_init = hit_select_config_reg[`TMS_BIT_FAST_INIT]
        & ~measure_clock_config_reg[`TMS_BIT_RANGE2];
    wire start_jitter_enable = cfg5_reg[`TMS_BIT_JITTER];
    wire hit_wr = is_write && wr_adr == `TMS_REG_HIT_SELECT;
    wire [3:0] first_operand_select = hit_select_config_reg[`TMS_FIRST_SEL_LSB +: 4];
    wire [3:0] second_operand_select = hit_select_config_reg[`TMS_SECOND_SEL_LSB +: 4];

    // Register writes on full 32-bit frame, POR clears all
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            measure_clock_config_reg <= `TMS_CFG_RESET;
            hit_select_config_reg <= `TMS_CFG_RESET;
            stop_window_first_config_reg <= `TMS_CFG_RESET;
            stop_window_second_config_reg <= `TMS_CFG_RESET;
            cfg4_reg <= `TMS_CFG_RESET;
            cfg5_reg <= `TMS_CFG_RESET;
        end else if (por) begin
            measure_clock_config_reg <= `TMS_CFG_RESET;
            hit_select_config_reg <= `TMS_CFG_RESET;
            stop_window_first_config_reg <= `TMS_CFG_RESET;
            stop_window_second_config_reg <= `TMS_CFG_RESET;
            cfg4_reg <= `TMS_CFG_RESET;
            cfg5_reg <= `TMS_CFG_RESET;
        end else if (is_write) begin
            case (wr_adr)
                `TMS_REG_MEASURE_CLOCK: measure_clock_config_reg <= frame[23:0];
                `TMS_REG_HIT_SELECT: hit_select_config_reg <= frame[23:0];
                `TMS_REG_WINDOW_FIRST: stop_window_first_config_reg <= frame[23:0];
                `TMS_REG_WINDOW_SECOND: stop_window_second_config_reg <= frame[23:0];
                `TMS_REG_CONFIG4: cfg4_reg <= frame[23:0];
                `TMS_REG_CONFIG5: cfg5_reg <= frame[23:0];
                default: cfg5_reg <= cfg5_reg;
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_SETTLE = 3'd1;
    localparam ST_FIRE = 3'd2;
    localparam ST_MEAS = 3'd3;
    localparam ST_CAL = 3'd4;
    localparam ST_DONE = 3'd5;

    reg [2:0] state_reg;
    reg cal_mode_reg;
    reg armed_reg; // Start-cycle accepted only after init or quick re-arm
    reg [20:0] tmr_reg;
    reg [20:0] t0_reg;
    reg [1:0] hits_reg;
    reg [1:0] pulses_reg;
    reg [4:0] pdiv_reg;
    reg [20:0] hit_time_reg [0:2];
    reg [31:0] res_reg [0:2];
    reg [15:0] status_reg;
    reg [7:0] lfsr_reg;
    reg [7:0] alu_cnt_reg;
    reg stop_d_reg;
    reg start_d_reg;
    wire stop_edge = stop_channel_one_in & ~stop_d_reg;
    wire start_edge = start_in & ~start_d_reg;
    wire cmd_init = opc_valid && opc == `TMS_OPC_INIT;
    wire cmd_cycle = opc_valid && opc == `TMS_OPC_START_CYCLE;
    wire cmd_cal = opc_valid && opc == `TMS_OPC_CAL_RES;
    wire osc_always = measure_clock_config_reg[`TMS_BIT_FAST_OSC];
    // Window reached for the next hit
    reg win_ok;
    always @* begin
        case (hits_reg)
            2'd0: win_ok = tmr_reg >= W1_CYC[20:0];
            2'd1: win_ok = tmr_reg >= W2_CYC[20:0];
            default: win_ok = tmr_reg >= W3_CYC[20:0];
        endcase
    end
    // Selects hit time by operand code, start maps to zero
    function [20:0] sel_time;
        input [3:0] code;
        input [20:0] h0;
        input [20:0] h1;
        input [20:0] h2;
        begin
            case (code)
                4'h3: sel_time = h0;
                4'h4: sel_time = h1;
                4'h5: sel_time = h2;
                default: sel_time = 21'd0;
            endcase
        end
    endfunction
    wire [20:0] alu_diff = sel_time(second_operand_select, hit_time_reg[0], hit_time_reg[1],
        hit_time_reg[2]) - sel_time(first_operand_select, hit_time_reg[0], hit_time_reg[1],
        hit_time_reg[2]);

    // Main measurement sequence
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cal_mode_reg <= 1'b0;
            armed_reg <= 1'b0;
            tmr_reg <= 21'd0;
            t0_reg <= 21'd0;
            hits_reg <= 2'd0;
            pulses_reg <= 2'd0;
            pdiv_reg <= 5'd0;
            status_reg <= 16'h0000;
            lfsr_reg <= 8'h01;
            alu_cnt_reg <= 8'h00;
            stop_d_reg <= 1'b0;
            start_d_reg <= 1'b0;
            fire_out <= 1'b0;
            fast_osc_on_out <= 1'b0;
            done_line_n_out <= 1'b1;
            hit_time_reg[0] <= 21'd0;
            hit_time_reg[1] <= 21'd0;
            hit_time_reg[2] <= 21'd0;
            res_reg[0] <= 32'h0000_0000;
            res_reg[1] <= 32'h0000_0000;
            res_reg[2] <= 32'h0000_0000;
        end else begin
            stop_d_reg <= stop_channel_one_in;
            start_d_reg <= start_in;
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            tmr_reg <= tmr_reg + 21'd1;
            // Recompute after hit selection rewrite
            if (hit_wr) alu_cnt_reg <= ALU_CYC[7:0];
            else if (alu_cnt_reg != 8'h00) begin
                alu_cnt_reg <= alu_cnt_reg - 8'h01;
                if (alu_cnt_reg == 8'h01) res_reg[0] <= {11'h000, alu_diff};
            end
            if (cmd_init || cmd_cycle || cmd_cal || por) done_line_n_out <= 1'b1;
            if (cmd_init || por) begin
                state_reg <= ST_IDLE;
                fast_osc_on_out <= osc_always;
                status_reg <= 16'h0000;
                armed_reg <= cmd_init;
                hits_reg <= 2'd0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if ((cmd_cycle && armed_reg) || cmd_cal) begin
                            cal_mode_reg <= cmd_cal;
                            fast_osc_on_out <= 1'b1;
                            tmr_reg <= 21'd0;
                            hits_reg <= 2'd0;
                            pulses_reg <= 2'd0;
                            state_reg <= osc_always ? (cmd_cal ? ST_CAL : ST_FIRE) : ST_SETTLE;
                        end
                    end
                    ST_SETTLE: begin
                        if (tmr_reg >= SETTLE_CYC - 1) begin
                            tmr_reg <= 21'd0;
                            state_reg <= cal_mode_reg ? ST_CAL : ST_FIRE;
                        end
                    end
                    ST_CAL: begin
                        if (tmr_reg >= CAL_CYC - 1) begin
                            res_reg[0] <= {11'h000, tmr_reg + 21'd1};
                            state_reg <= ST_DONE;
                        end
                    end
                    ST_FIRE: begin
                        // Pulse clock: 20 MHz system clock toggled every 10 cycles, reduced to 1 MHz here
                        pdiv_reg <= pdiv_reg + 5'd1;
                        if (pdiv_reg == FIRE_HALF - 1) begin
                            pdiv_reg <= 5'd0;
                            fire_out <= ~fire_out;
                            if (fire_out) begin
                                pulses_reg <= pulses_reg + 2'd1;
                                if (pulses_reg == `TMS_FIRE_PULSES - 1) begin
                                    state_reg <= ST_MEAS;
                                    tmr_reg <= 21'd0;
                                    t0_reg <= start_jitter_enable ?
                                        {13'd0, lfsr_reg} : 21'd0;
                                end
                            end
                        end
                    end
                    ST_MEAS: begin
                        if (stop_edge && win_ok) begin
                            hit_time_reg[hits_reg] <= tmr_reg + t0_reg;
                            hits_reg <= hits_reg + 2'd1;
                            if (hits_reg == `TMS_HITS - 1) begin
                                res_reg[0] <= {11'h000, hit_time_reg[0]};
                                state_reg <= ST_DONE;
                            end
                        end else if (tmr_reg >= TIMEOUT_CYC - 1) begin
                            status_reg <= status_reg | `TMS_STAT_TIMEOUT;
                            state_reg <= ST_DONE;
                        end
                        if (start_edge) tmr_reg <= 21'd0;
                    end
                    ST_DONE: begin
                        done_line_n_out <= 1'b0;
                        fast_osc_on_out <= osc_always;
                        status_reg[1:0] <= hits_reg;
                        if (hits_reg == `TMS_HITS) res_reg[1] <= {11'h000, hit_time_reg[1]};
                        if (!cal_mode_reg) armed_reg <= fast_init;
                        if (fast_init && !cal_mode_reg) begin
                            hits_reg <= 2'd0;
                            status_reg[15:14] <= 2'b00;
                        end
                        state_reg <= ST_IDLE;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read word for opcodes 0xB0..0xB4
    // ----------------------------------------
    always @* begin
        rd_word = 32'h0000_0000;
        if (opc[7:3] == `TMS_OPC_READ_HI) begin
            case (opc[2:0])
                3'h0: rd_word = res_reg[0];
                3'h1: rd_word = res_reg[1];
                3'h2: rd_word = {11'h000, hit_time_reg[2]};
                `TMS_RD_STATUS: rd_word = {status_reg, 16'h0000};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end
endmodule // tms_measure_sequencer

// >>> bench/tms_measure_sequencer_asserts.sv
`timescale 1ns/1ps
`include "tms_regs.vh"
module tms_measure_sequencer_asserts #(
    parameter SETTLE_CYC = 20,
    parameter TIMEOUT_CYC = 200,
    parameter CAL_CYC = 40
) (
    // System
    input wire clk_sys_in,
    input wire rst_n_in,
    // Serial port
    input wire ssn_in,
    input wire sck_in,
    input wire si_in,
    input wire so_out,
    // Measurement pins
    input wire start_in,
    input wire stop_channel_one_in,
    input wire fire_out,
    input wire fast_osc_on_out,
    input wire done_line_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] osc_cnt;
    logic [2:0] fire_cnt;
    // Age of the oscillator session and fire pulses seen in it
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_cnt <= 16'h0000;
            fire_cnt <= 3'h0;
        end else if (!fast_osc_on_out) begin
            osc_cnt <= 16'h0000;
            fire_cnt <= 3'h0;
        end else begin
            osc_cnt <= (osc_cnt == 16'hFFFF) ? osc_cnt : osc_cnt + 16'h0001;
            fire_cnt <= fire_cnt + {2'b00, $rose(fire_out) && fire_cnt != 3'h7};
        end
    end
    sequence s_bus_idle;
        ssn_in [*8];
    endsequence
    sequence s_sck_low;
        (!ssn_in && !sck_in) [*5];
    endsequence
    property p_reset_idle;
        $rose(rst_n_in) |-> done_line_n_out && !fire_out && !fast_osc_on_out;
    endproperty
    property p_settle;
        fire_out |-> osc_cnt >= SETTLE_CYC - 1;
    endproperty
    property p_osc_span;
        osc_cnt <= SETTLE_CYC + TIMEOUT_CYC + 400;
    endproperty
    property p_fire_count;
        fire_cnt <= `TMS_FIRE_PULSES;
    endproperty
    property p_fire_spacing;
        $rose(fire_out) |=> (!$rose(fire_out)) [*8];
    endproperty
    property p_done_holds;
        s_bus_idle ##0 !done_line_n_out |=> !done_line_n_out;
    endproperty
    property p_release_in_frame;
        $rose(done_line_n_out) |-> !ssn_in;
    endproperty
    property p_so_stable;
        s_sck_low |-> $stable(so_out);
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
    a_settle: assert property (p_settle)
        else $error("fire before oscillator settled");
    a_osc_span: assert property (p_osc_span)
        else $error("oscillator session too long");
    a_fire_count: assert property (p_fire_count)
        else $error("too many fire pulses");
    a_fire_spacing: assert property (p_fire_spacing)
        else $error("fire pulses too close");
    a_done_holds: assert property (p_done_holds)
        else $error("done released without a frame");
    a_release_in_frame: assert property (p_release_in_frame)
        else $error("done released outside a frame");
    a_so_stable: assert property (p_so_stable)
        else $error("read data moved while serial clock low");
endmodule // tms_measure_sequencer_asserts
bind tms_measure_sequencer tms_measure_sequencer_asserts #(.SETTLE_CYC(SETTLE_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC), .CAL_CYC(CAL_CYC)) u_chk (.clk_sys_in, .rst_n_in,
    .ssn_in, .sck_in, .si_in, .so_out, .start_in, .stop_channel_one_in, .fire_out,
    .fast_osc_on_out, .done_line_n_out);

// >>> bench/tms_host_model.sv
`timescale 1ns/1ps
// ----
// Host driving the serial port, mode 1
// ----
module tms_host_model (
    // System
    input wire logic clk_in,
    // Serial pins
    output logic ssn_n_out,
    output logic sck_out,
    output logic si_out,
    input wire logic so_in
);
    // Idle bus: select high, clock still and low
    initial begin
        ssn_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // One bit: drive on rising clock, sample on falling
    task automatic bit_x(input logic b, output logic r);
        @(negedge clk_in);
        sck_out = 1'b1;
        si_out = b;
        repeat (4) @(negedge clk_in);
        r = so_in;
        sck_out = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask
    // Whole frame: opcode, then 24 write bits or 32 read bits
    task automatic frame(input logic [7:0] opc, input logic [23:0] wd, input logic wr,
        input logic rdf, output logic [31:0] rd);
        logic r;
        int i;
        rd = 32'h0000_0000;
        @(negedge clk_in);
        ssn_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (i = 7; i >= 0; i--) begin
            bit_x(opc[i], r);
        end
        for (i = 23; i >= 0 && wr; i--) begin
            bit_x(wd[i], r);
        end
        for (i = 31; i >= 0 && rdf; i--) begin
            bit_x(~si_out, r);
            rd[i] = r;
        end
        repeat (8) @(negedge clk_in);
        ssn_n_out = 1'b1;
        si_out = ~si_out; // Released line keeps no stale level
        repeat (4) @(negedge clk_in);
    endtask
endmodule // tms_host_model

// >>> bench/tms_measure_sequencer_tb.sv
`timescale 1ns/1ps
`include "tms_regs.vh"
module tms_measure_sequencer_tb;
    // ----
    // Clock, reset and pins
    // ----
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start_in = 1'b0;
    logic stop_in = 1'b0;
    wire sel_n, sck, si, so, fire, osc, done_n;
    int n_errors = 0;
    int checks = 0;
    int nfire = 0;
    logic [31:0] rd;
    logic [31:0] res0_plain;
    localparam int CAL = 40;
    // Free-running system clock and fire pulse counter
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge fire) nfire++;
    tms_measure_sequencer #(.SETTLE_CYC(20), .TIMEOUT_CYC(2000), .CAL_CYC(CAL)) u_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ssn_in(sel_n), .sck_in(sck),
        .si_in(si), .so_out(so), .start_in(start_in), .stop_channel_one_in(stop_in),
        .fire_out(fire), .fast_osc_on_out(osc), .done_line_n_out(done_n));
    tms_host_model u_host (.clk_in(clk_sys_in), .ssn_n_out(sel_n), .sck_out(sck),
        .si_out(si), .so_in(so));
    // ----
    // Shared tasks
    // ----
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic send_cmd(input logic [7:0] opc);
        u_host.frame(opc, 24'h00_0000, 1'b0, 1'b0, rd);
    endtask
    task automatic write_reg(input logic [2:0] a, input logic [23:0] d);
        u_host.frame({`TMS_OPC_WRITE_HI, a}, d, 1'b1, 1'b0, rd);
    endtask
    task automatic read_reg(input logic [2:0] a, output logic [31:0] q);
        u_host.frame({`TMS_OPC_READ_HI, a}, 24'h00_0000, 1'b0, 1'b1, q);
    endtask
    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (done_n !== 1'b0 && n < lim) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask
    // Optional init, start, fire burst, start event, three stops, status
    task automatic meas(input int stop_cyc, input logic init, output logic [31:0] st);
        int n;
        int k;
        nfire = 0;
        if (init) begin
            send_cmd(`TMS_OPC_INIT);
            cmp_val({31'h0, done_n}, 32'h1);
        end
        send_cmd(`TMS_OPC_START_CYCLE);
        for (n = 0; nfire < 3 && n < 1000; n++) begin
            @(negedge clk_sys_in);
        end
        repeat (20) @(negedge clk_sys_in);
        start_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        start_in = 1'b0;
        repeat (stop_cyc - 2) @(negedge clk_sys_in);
        for (k = 0; k < 3; k++) begin
            stop_in = 1'b1;
            repeat (2) @(negedge clk_sys_in);
            stop_in = 1'b0;
            repeat (18) @(negedge clk_sys_in);
        end
        wait_done(3000, n);
        cmp_val({31'h0, done_n}, 32'h0);
        cmp_val(nfire, 32'h3);
        repeat (4) @(negedge clk_sys_in);
        cmp_val({31'h0, osc}, 32'h0);
        read_reg(`TMS_RD_STATUS, st);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_config(input logic jit);
        logic [23:0] cfg [0:5];
        int i;
        cfg = '{24'h33_8268, 24'h31_4000, 24'hE0_3200, 24'h08_3300, 24'h20_3400,
            24'h08_0000};
        cfg[5][`TMS_BIT_JITTER] = jit;
        send_cmd(`TMS_OPC_POR);
        for (i = 0; i < 6; i++) begin
            write_reg(i[2:0], cfg[i]);
        end
        write_reg(3'h7, 24'hFF_FFFF);
        cmp_val({31'h0, done_n}, 32'h1);
        $display("test config done");
    endtask
    task automatic t_cal;
        int n;
        send_cmd(`TMS_OPC_CAL_RES);
        wait_done(400, n);
        cmp_val({31'h0, done_n}, 32'h0);
        cmp_val({31'h0, n >= CAL - 20 && n <= CAL + 40}, 32'h1);
        read_reg(3'h0, rd);
        cmp_val(rd, CAL);
        $display("test calibration done");
    endtask
    task automatic t_timeout;
        logic [31:0] st;
        meas(200, 1'b1, st);
        cmp_val({16'h0, st[31:16] & `TMS_STAT_TIMEOUT}, {16'h0, `TMS_STAT_TIMEOUT});
        $display("test early stops done");
    endtask
    task automatic t_hits;
        logic [31:0] st, r0, r1, r2, r3;
        meas(1100, 1'b1, st);
        cmp_val({16'h0, st[31:16] & 16'h0600}, 32'h0);
        read_reg(3'h0, res0_plain);
        write_reg(`TMS_REG_HIT_SELECT, 24'h41_4000);
        repeat (`TMS_ALU_NS / `TMS_CLK_NS) @(negedge clk_sys_in);
        read_reg(3'h0, r3);
        write_reg(`TMS_REG_HIT_SELECT, 24'h51_4000);
        repeat (`TMS_ALU_NS / `TMS_CLK_NS) @(negedge clk_sys_in);
        read_reg(3'h0, r0);
        read_reg(3'h1, r1);
        read_reg(3'h2, r2);
        cmp_val(r3, r1);
        cmp_val(r0, r2);
        cmp_val(r2 - r1, 32'h0000_0014);
        cmp_val(r1 - res0_plain, 32'h0000_0014);
        $display("test windowed hits done");
    endtask
    task automatic t_jitter;
        logic [31:0] st, r;
        t_config(1'b1);
        meas(1100, 1'b1, st);
        read_reg(3'h0, r);
        cmp_val({31'h0, r != res0_plain}, 32'h1);
        $display("test start jitter done");
    endtask
    // Range one with quick re-arm: second cycle runs without init
    task automatic t_fast;
        logic [31:0] st;
        write_reg(`TMS_REG_MEASURE_CLOCK, 24'h33_8260);
        write_reg(`TMS_REG_HIT_SELECT, 24'h31_C000);
        meas(1100, 1'b1, st);
        meas(1100, 1'b0, st);
        cmp_val({16'h0, st[31:16] & 16'h0600}, 32'h0);
        $display("test quick re-arm done");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        cmp_val({29'h0, done_n, fire, osc}, 32'h4);
        t_config(1'b0);
        t_cal;
        t_timeout;
        t_hits;
        t_jitter;
        t_fast;
        final_report;
    end
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        n_errors++;
        final_report;
    end
endmodule // tms_measure_sequencer_tb
